/* src/primary_regs_defs.vh */
// Offsets, field positions and reset values of the primary configuration and control registers
`ifndef PRIMARY_REGS_DEFS_VH
`define PRIMARY_REGS_DEFS_VH

`define REG_ADDR_W              7
`define REG_DATA_W              16

`define OFS_PRIMARY_CONFIG      7'h04
`define OFS_PRIMARY_CONTROL     7'h06

`define RST_PRIMARY_CONFIG      16'h00C4
`define RST_PRIMARY_CONTROL     16'h0001

`define BIT_PARITY              0
`define BIT_LAST_MSG_INVALID    1

`define BIT_FAULT_B_CLEAR_MODE  7
`define BIT_FAULT_A_CLEAR_MODE  6
`define BIT_RX_PARITY_CHECK_EN  2

`define BIT_CLEAR_SECONDARY     6
`define BIT_CLEAR_PRIMARY       5
`define BIT_BLANK_REFRESH_REQ   3
`define BIT_BLANK_SELECT_REQ    2

`endif

/* src/primary_config_control_regs.v */
// Primary configuration and run-time control registers with fault output handling
`timescale 1ns/100ps
`include "primary_regs_defs.vh"

module primary_config_control_regs #(
    parameter STICKY_W = 8
) (
    input  wire                       core_clk,
    input  wire                       rst_n,
    input  wire                       wr_en,
    input  wire [`REG_ADDR_W-1:0]     wr_addr,
    input  wire [`REG_DATA_W-1:0]     wr_data,
    input  wire                       rd_en,
    input  wire [`REG_ADDR_W-1:0]     rd_addr,
    output reg  [`REG_DATA_W-1:0]     rd_data,
    output reg                        rd_valid,
    output reg                        rd_hit,
    input  wire                       msg_done,
    input  wire                       msg_discarded,
    input  wire                       class_a_event,
    input  wire                       class_b_event,
    input  wire                       fault_a_set,
    input  wire                       fault_b_set,
    input  wire [STICKY_W-1:0]        sticky_set,
    input  wire [STICKY_W-1:0]        sticky_hold,
    output reg  [STICKY_W-1:0]        sticky_flags,
    output reg                        fault_out_a_n,
    output reg                        fault_out_b_n,
    output reg                        rx_parity_check_enable,
    output reg                        blank_time_select_request,
    output reg                        blank_time_refresh_request,
    output reg                        clear_secondary_sticky
);

    reg                        fault_b_clear_mode;
    reg                        fault_a_clear_mode;
    reg                        last_msg_invalid;
    reg                        clear_primary_sticky;

    wire                       wr_config;
    wire                       wr_control;
    reg  [`REG_DATA_W-1:0]     config_word;
    reg  [`REG_DATA_W-1:0]     control_word;
    reg  [`REG_DATA_W-1:0]     next_rd_data;
    reg                        next_rd_hit;
    reg                        next_fault_out_a_n;
    reg                        next_fault_out_b_n;
    // Read word before its parity bit is filled in
    reg  [`REG_DATA_W-1:0]     raw_rd_word;
    wire                       release_a;
    wire                       release_b;

    // Reset words kept whole so each field takes its own bit and no width is cut
    localparam [`REG_DATA_W-1:0] CONFIG_RESET  = `RST_PRIMARY_CONFIG;
    localparam [`REG_DATA_W-1:0] CONTROL_RESET = `RST_PRIMARY_CONTROL;

    assign wr_config  = wr_en && (wr_addr == `OFS_PRIMARY_CONFIG);
    assign wr_control = wr_en && (wr_addr == `OFS_PRIMARY_CONTROL);

    // Fault B clear mode
    always @(posedge core_clk) begin
        if (!rst_n) begin
            fault_b_clear_mode <= CONFIG_RESET[`BIT_FAULT_B_CLEAR_MODE];
        end else if (wr_config) begin
            fault_b_clear_mode <= wr_data[`BIT_FAULT_B_CLEAR_MODE];
        end
    end

    // Fault A clear mode
    always @(posedge core_clk) begin
        if (!rst_n) begin
            fault_a_clear_mode <= CONFIG_RESET[`BIT_FAULT_A_CLEAR_MODE];
        end else if (wr_config) begin
            fault_a_clear_mode <= wr_data[`BIT_FAULT_A_CLEAR_MODE];
        end
    end

    // Receive parity check enable; the transmit side never consults it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rx_parity_check_enable <= CONFIG_RESET[`BIT_RX_PARITY_CHECK_EN];
        end else if (wr_config) begin
            rx_parity_check_enable <= wr_data[`BIT_RX_PARITY_CHECK_EN];
        end
    end

    // Blanking time select request, a plain stored level
    always @(posedge core_clk) begin
        if (!rst_n) begin
            blank_time_select_request <= CONTROL_RESET[`BIT_BLANK_SELECT_REQ];
        end else if (wr_control) begin
            blank_time_select_request <= wr_data[`BIT_BLANK_SELECT_REQ];
        end
    end

    // Command bits live one cycle so each action fires exactly once
    // Writing 0 to a command bit leaves nothing behind
    always @(posedge core_clk) begin
        if (!rst_n) begin
            clear_primary_sticky <= CONTROL_RESET[`BIT_CLEAR_PRIMARY];
        end else begin
            clear_primary_sticky <= wr_control && wr_data[`BIT_CLEAR_PRIMARY];
        end
    end

    // Secondary clear pulse
    always @(posedge core_clk) begin
        if (!rst_n) begin
            clear_secondary_sticky <= CONTROL_RESET[`BIT_CLEAR_SECONDARY];
        end else begin
            clear_secondary_sticky <= wr_control && wr_data[`BIT_CLEAR_SECONDARY];
        end
    end

    // Refresh request pulse
    always @(posedge core_clk) begin
        if (!rst_n) begin
            blank_time_refresh_request <= CONTROL_RESET[`BIT_BLANK_REFRESH_REQ];
        end else begin
            blank_time_refresh_request <= wr_control && wr_data[`BIT_BLANK_REFRESH_REQ];
        end
    end

    // Outcome of the last message, kept until the next one ends
    // A message still in flight leaves the flag alone until it is judged
    // Reset shows a clean history
    always @(posedge core_clk) begin
        if (!rst_n) begin
            last_msg_invalid <= 1'b0;
        end else if (msg_done) begin
            last_msg_invalid <= msg_discarded;
        end
    end

    // Primary sticky flags; a new event beats a clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < STICKY_W; i = i + 1) begin : g_sticky
            wire set_now;
            wire clear_now;

            // Per-flag set and clear terms
            assign set_now   = sticky_set[i];
            assign clear_now = clear_primary_sticky && !sticky_hold[i];

            always @(posedge core_clk) begin
                if (!rst_n) begin
                    sticky_flags[i] <= 1'b0;
                end else if (set_now) begin
                    sticky_flags[i] <= 1'b1;
                end else if (clear_now) begin
                    sticky_flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Release terms; a clear that meets an active event in mode 1 is dropped, not retried
    // Each output keeps its own term so one class never blocks the other
    // fault A and fault B clear modes
    assign release_a = clear_primary_sticky && (!fault_a_clear_mode || !class_a_event);
    assign release_b = clear_primary_sticky && (!fault_b_clear_mode || !class_b_event);

    // Fault A next value; an assert request wins over a clear in the same cycle
    always @* begin
        next_fault_out_a_n = fault_out_a_n;
        if (fault_a_set) begin
            next_fault_out_a_n = 1'b0;
        end else if (release_a) begin
            next_fault_out_a_n = 1'b1;
        end
    end

    // Fault B next value; same priority as fault A
    always @* begin
        next_fault_out_b_n = fault_out_b_n;
        if (fault_b_set) begin
            next_fault_out_b_n = 1'b0;
        end else if (release_b) begin
            next_fault_out_b_n = 1'b1;
        end
    end

    // Fault A output, released after reset
    always @(posedge core_clk) begin
        if (!rst_n) begin
            fault_out_a_n <= 1'b1;
        end else begin
            fault_out_a_n <= next_fault_out_a_n;
        end
    end

    // Fault B output, released after reset
    always @(posedge core_clk) begin
        if (!rst_n) begin
            fault_out_b_n <= 1'b1;
        end else begin
            fault_out_b_n <= next_fault_out_b_n;
        end
    end

    // Configuration word before parity; reserved bits read as zero
    always @* begin
        config_word = 16'h0000;
        config_word[`BIT_FAULT_B_CLEAR_MODE] = fault_b_clear_mode;
        config_word[`BIT_FAULT_A_CLEAR_MODE] = fault_a_clear_mode;
        config_word[`BIT_RX_PARITY_CHECK_EN] = rx_parity_check_enable;
        config_word[`BIT_LAST_MSG_INVALID]   = last_msg_invalid;
    end

    // Control word before parity; command bits read back as they stand
    // A command bit therefore reads 1 only in its own action cycle
    always @* begin
        control_word = 16'h0000;
        control_word[`BIT_CLEAR_SECONDARY]   = clear_secondary_sticky;
        control_word[`BIT_CLEAR_PRIMARY]     = clear_primary_sticky;
        control_word[`BIT_BLANK_REFRESH_REQ] = blank_time_refresh_request;
        control_word[`BIT_BLANK_SELECT_REQ]  = blank_time_select_request;
        control_word[`BIT_LAST_MSG_INVALID]  = last_msg_invalid;
    end

    // Read mux; unmapped addresses return zero with rd_hit low
    always @* begin
        raw_rd_word = 16'h0000;
        next_rd_hit = 1'b0;
        case (rd_addr)
            `OFS_PRIMARY_CONFIG: begin
                raw_rd_word = config_word;
                next_rd_hit = 1'b1;
            end
            `OFS_PRIMARY_CONTROL: begin
                raw_rd_word = control_word;
                next_rd_hit = 1'b1;
            end
            default: begin
                raw_rd_word = 16'h0000;
                next_rd_hit = 1'b0;
            end
        endcase
    end

    // Parity stage; only mapped words carry parity, so an unmapped read stays all zero
    always @* begin
        next_rd_data = raw_rd_word;
        if (next_rd_hit) begin
            next_rd_data[`BIT_PARITY] = ~(^raw_rd_word[`REG_DATA_W-1:1]);
        end
    end

    // Read strobe answered exactly one cycle later
    // Unmapped addresses are answered too, so the host never waits
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
        end
    end

    // Registered read port; data holds until the next read
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
            rd_hit  <= 1'b0;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
            rd_hit  <= next_rd_hit;
        end
    end

endmodule // primary_config_control_regs

/* dv/regs_checker_assertions.sv */
// Port assertions for the primary register block
`timescale 1ns/100ps
`include "primary_regs_defs.vh"
module regs_checker #(parameter STICKY_W = 8) (
    input wire core_clk, rst_n, wr_en, rd_valid, rd_hit, msg_done, msg_discarded, rx_parity_check_enable,
    input wire blank_time_select_request, blank_time_refresh_request, clear_secondary_sticky,
    input wire [`REG_ADDR_W-1:0] wr_addr,
    input wire [`REG_DATA_W-1:0] wr_data, rd_data,
    input wire [STICKY_W-1:0]    sticky_set, sticky_hold, sticky_flags
);
    reg  clr_p, lmi_q;
    wire wcfg = wr_en && wr_addr == `OFS_PRIMARY_CONFIG;
    wire wctl = wr_en && wr_addr == `OFS_PRIMARY_CONTROL;
    // The clear cycle is internal, so it is rebuilt from the write
    always @(posedge core_clk) begin
        clr_p <= rst_n && wctl && wr_data[5];
        lmi_q <= rst_n && (msg_done ? msg_discarded : lmi_q);
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_par_en; wcfg |=> rx_parity_check_enable == $past(wr_data[2]); endproperty
    a_par_en: assert property (p_par_en) else $error("parity enable");
    property p_sel; wctl |=> blank_time_select_request == $past(wr_data[2]); endproperty
    a_sel: assert property (p_sel) else $error("select request");
    property p_refresh; wctl |=> blank_time_refresh_request == $past(wr_data[3]); endproperty
    a_refresh: assert property (p_refresh) else $error("refresh pulse");
    property p_clr_sec; wctl |=> clear_secondary_sticky == $past(wr_data[6]); endproperty
    a_clr_sec: assert property (p_clr_sec) else $error("secondary clear");
    property p_parity; rd_valid && rd_hit |-> ^rd_data; endproperty
    a_parity: assert property (p_parity) else $error("even word");
    property p_lmi; rd_valid && rd_hit |-> rd_data[1] == $past(lmi_q); endproperty
    a_lmi: assert property (p_lmi) else $error("invalid flag");
    property p_sticky; clr_p |=> (sticky_flags & ~($past(sticky_set) | $past(sticky_hold))) == 0; endproperty
    a_sticky: assert property (p_sticky) else $error("sticky kept");
    property p_hold; clr_p |=> (~sticky_flags & $past(sticky_hold) & $past(sticky_flags)) == 0; endproperty
    a_hold: assert property (p_hold) else $error("held flag lost");
endmodule // regs_checker
bind primary_config_control_regs regs_checker #(.STICKY_W(STICKY_W)) u_regs_checker (.*);

/* dv/host_master_model.sv */
// Host model issuing register writes and reads
`timescale 1ns/100ps
`include "primary_regs_defs.vh"
module host_master_model (
    input  wire                   core_clk,
    output reg                    wr_en, rd_en,
    output reg  [`REG_ADDR_W-1:0] wr_addr, rd_addr,
    output reg  [`REG_DATA_W-1:0] wr_data
);
    initial {wr_en, rd_en, wr_addr, rd_addr, wr_data} = 0;
    // Released lines flip so a stale value never passes
    task xfer(input w, input [6:0] a, input [15:0] d);
        @(negedge core_clk);
        {wr_en, rd_en, wr_addr, rd_addr, wr_data} = {w, !w, a, a, d};
        @(negedge core_clk);
        {wr_en, rd_en, wr_addr, rd_addr, wr_data} = {2'b00, ~a, ~a, ~d};
    endtask
endmodule // host_master_model

/* dv/tb_primary_config_control_regs.sv */
// Random and corner tests of the primary register block
`timescale 1ns/100ps
`include "primary_regs_defs.vh"
module tb_primary_config_control_regs;
    reg         core_clk, rst_n, msg_done, msg_discarded, class_a_event, class_b_event, fault_a_set, fault_b_set;
    reg  [7:0]  sticky_set, sticky_hold, st;
    reg  [15:0] d;
    reg  [31:0] seed;
    wire [6:0]  wr_addr, rd_addr;
    wire [15:0] wr_data, rd_data;
    wire [7:0]  sticky_flags;
    wire        wr_en, rd_en, rd_valid, rd_hit, fault_out_a_n, fault_out_b_n, rx_parity_check_enable;
    wire        blank_time_select_request, blank_time_refresh_request, clear_secondary_sticky;
    integer     fail_count, total_checks, i;
    primary_config_control_regs u_primary_config_control_regs (.*);
    host_master_model u_host_master_model (.*);
    initial begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end
    function [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    // Readback word: invalid flag in bit 1, odd parity in bit 0
    function [15:0] word(input [15:0] f, input l);
        word = {f[15:2], l, ~^{f[15:2], l}};
    endfunction
    task check(input [18:0] seen, input [18:0] exp);
        total_checks = total_checks + 1;
        fail_count = fail_count + (seen !== exp);
        if (seen !== exp) $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count = fail_count + 1;
        test_done;
    end
    initial begin
        {rst_n, msg_done, msg_discarded, class_a_event, class_b_event, fault_a_set, fault_b_set} = 0;
        {sticky_set, sticky_hold, seed} = 31;
        fail_count = 0;
        total_checks = 0;
        repeat (6) @(negedge core_clk);
        rst_n = 1;
        u_host_master_model.xfer(0, 7'h04, 0);
        check({rx_parity_check_enable, rd_valid, rd_hit, rd_data}, {3'b111, word(16'h00C4, 0)});
        u_host_master_model.xfer(0, 7'h06, 0);
        check({rd_valid, rd_hit, rd_data}, {2'b11, word(16'h0001, 0)});
        u_host_master_model.xfer(0, 7'h05, 0);
        check({rd_valid, rd_hit, rd_data}, 18'h20000);
        // Faults are raised every pass; clear bit and modes come from the random word
        for (i = 0; i < 12; i = i + 1) begin
            seed = xs(seed);
            d = seed[15:0];
            {msg_done, msg_discarded} = {1'b1, seed[20]};
            u_host_master_model.xfer(1, 7'h04, d);
            {msg_done, fault_a_set, fault_b_set, sticky_set} = {3'b011, seed[31:24]};
            {class_a_event, class_b_event, sticky_hold} = seed[25:16];
            check(rx_parity_check_enable, d[2]);
            u_host_master_model.xfer(0, 7'h04, 0);
            check(rd_data, word(d & 16'h00C4, seed[20]));
            {fault_a_set, fault_b_set, sticky_set} = 0;
            st = sticky_flags;
            u_host_master_model.xfer(1, 7'h06, d);
            check(blank_time_select_request, d[2]);
            check(clear_secondary_sticky, d[6]);
            check(blank_time_refresh_request, d[3]);
            u_host_master_model.xfer(0, 7'h06, 0);
            check(rd_data, word(d & 16'h0004, seed[20]));
            check(fault_out_a_n, d[5] & !(d[6] & class_a_event));
            check(fault_out_b_n, d[5] & !(d[7] & class_b_event));
            check(sticky_flags, d[5] ? st & sticky_hold : st);
        end
        test_done;
    end
endmodule // tb_primary_config_control_regs
